// *** hdl/pif_pkg.sv ***
// Package of constants for the peripheral interrupt enable and flag block
`default_nettype none
package pif_pkg;
    localparam logic [7:0] FLAGS_ADDR    = 8'h0C;
    localparam logic [7:0] ENABLES_ADDR  = 8'h8C;
    localparam logic [7:0] IMPL_MASK     = 8'hC9;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam int         NVM_BIT       = 7;
    localparam int         CONV_BIT      = 6;
    localparam int         CMP_BIT       = 3;
    localparam int         TMR_BIT       = 0;
    localparam int         CORE_MIE_BIT  = 7;
    localparam int         CORE_PIE_BIT  = 6;
    localparam logic [11:0] APB_CTRL_OFF = 12'h000;
    localparam logic [11:0] APB_STAT_OFF = 12'h004;
    localparam logic [11:0] APB_DATA_OFF = 12'h008;
    localparam int         CTRL_GO_BIT   = 0;
    localparam int         CTRL_WR_BIT   = 1;
    localparam int         CTRL_SEL_BIT  = 2;
    localparam int         CTRL_DAT_LSB  = 8;
    localparam int         STAT_BUSY_BIT = 0;
    localparam int         STAT_REQ_BIT  = 1;
    localparam int         STAT_PEND_BIT = 2;
endpackage
`default_nettype wire

// *** hdl/pif_if.sv ***
// Interface joining the interrupt block and its core-side controller
`default_nettype none
interface pif_if;
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] core_ctrl;
    logic       periph_irq;
    logic       irq_to_core;
    modport dev (input addr, input wr_en, input rd_en, input wdata, input core_ctrl,
                 output rdata, output periph_irq, output irq_to_core);
    modport ctl (output addr, output wr_en, output rd_en, output wdata, output core_ctrl,
                 input rdata, input periph_irq, input irq_to_core);
endinterface
`default_nettype wire

// *** hdl/pif_dev.sv ***
// Peripheral interrupt enable and flag registers with request gating
`default_nettype none
module pif_dev (
    input  wire logic clk,
    input  wire logic rst_n,
    pif_if.dev        bus,
    input  wire logic nvm_write_done,
    input  wire logic conversion_done,
    input  wire logic comparator_change,
    input  wire logic timer_one_overflow
);
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] rdata;
        logic       preq;
        logic       irq;
    } pif_dev_state_t;

    pif_dev_state_t s_q;
    pif_dev_state_t s_d;
    logic [7:0]     ev;
    logic [7:0]     flg;

    always_comb begin
        ev                         = 8'h00;
        ev[pif_pkg::NVM_BIT]       = nvm_write_done;
        ev[pif_pkg::CONV_BIT]      = conversion_done;
        ev[pif_pkg::CMP_BIT]       = comparator_change;
        ev[pif_pkg::TMR_BIT]       = timer_one_overflow;
        s_d = s_q;
        flg = s_q.flags;
        if (bus.wr_en && bus.addr == pif_pkg::FLAGS_ADDR) begin
            flg = bus.wdata;
        end else if (bus.wr_en && bus.addr == pif_pkg::ENABLES_ADDR) begin
            s_d.enables = bus.wdata & pif_pkg::IMPL_MASK;
        end
        s_d.flags = (flg | ev) & pif_pkg::IMPL_MASK;
        if (bus.rd_en && bus.addr == pif_pkg::FLAGS_ADDR) begin
            s_d.rdata = s_q.flags;
        end else if (bus.rd_en && bus.addr == pif_pkg::ENABLES_ADDR) begin
            s_d.rdata = s_q.enables;
        end else if (bus.rd_en) begin
            s_d.rdata = 8'h00;
        end
        s_d.preq = |(s_q.flags & s_q.enables);
        s_d.irq  = s_d.preq && bus.core_ctrl[pif_pkg::CORE_PIE_BIT]
                   && bus.core_ctrl[pif_pkg::CORE_MIE_BIT];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.rdata       = s_q.rdata;
    assign bus.periph_irq  = s_q.preq;
    assign bus.irq_to_core = s_q.irq;
endmodule
`default_nettype wire

// *** hdl/pif_ctl.sv ***
// Core-side controller: APB registers drive accesses to the interrupt block
`default_nettype none
module pif_ctl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    pif_if.ctl               bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACC  = 3'b010,
        ST_DONE = 3'b100
    } pif_ctl_st_t;

    typedef struct packed {
        pif_ctl_st_t st;
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
        logic [7:0]  core_ctrl;
        logic [7:0]  rdata;
        logic [31:0] prdata;
        logic        pready;
    } pif_ctl_state_t;

    pif_ctl_state_t s_q;
    pif_ctl_state_t s_d;
    logic           acc;

    always_comb begin
        s_d        = s_q;
        s_d.wr     = 1'b0;
        s_d.rd     = 1'b0;
        s_d.pready = 1'b0;
        acc        = psel && penable && !s_q.pready;
        case (s_q.st)
            ST_IDLE: begin
            end
            ST_ACC: begin
                s_d.st = ST_DONE;
            end
            ST_DONE: begin
                s_d.rdata = bus.rdata;
                s_d.st    = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
        if (acc) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            if (paddr == pif_pkg::APB_CTRL_OFF) begin
                if (pwrite) begin
                    s_d.core_ctrl = pwdata[7:0];
                    if (pwdata[pif_pkg::CTRL_GO_BIT] && s_q.st == ST_IDLE) begin
                        s_d.addr  = pwdata[pif_pkg::CTRL_SEL_BIT] ? pif_pkg::ENABLES_ADDR : pif_pkg::FLAGS_ADDR;
                        s_d.wr    = pwdata[pif_pkg::CTRL_WR_BIT];
                        s_d.rd    = !pwdata[pif_pkg::CTRL_WR_BIT];
                        s_d.wdata = pwdata[pif_pkg::CTRL_DAT_LSB +: 8];
                        s_d.st    = ST_ACC;
                    end
                end else begin
                    s_d.prdata[7:0] = s_q.core_ctrl;
                end
            end else if (paddr == pif_pkg::APB_STAT_OFF) begin
                s_d.prdata[pif_pkg::STAT_BUSY_BIT] = s_q.st != ST_IDLE;
                s_d.prdata[pif_pkg::STAT_REQ_BIT]  = bus.irq_to_core;
                s_d.prdata[pif_pkg::STAT_PEND_BIT] = bus.periph_irq;
            end else if (paddr == pif_pkg::APB_DATA_OFF) begin
                s_d.prdata[7:0] = s_q.rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.addr      = s_q.addr;
    assign bus.wr_en     = s_q.wr;
    assign bus.rd_en     = s_q.rd;
    assign bus.wdata     = s_q.wdata;
    assign bus.core_ctrl = s_q.core_ctrl;
    assign prdata        = s_q.prdata;
    assign pready        = s_q.pready;
    assign pslverr       = 1'b0;
endmodule
`default_nettype wire

// *** verification/pif_asserts.sv ***
// Checker for the link between the interrupt block and its controller
`default_nettype none
module pif_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [7:0] core_ctrl,
    input wire logic       periph_irq,
    input wire logic       irq_to_core
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_pie_gates_irq: assert property (irq_to_core |-> $past(core_ctrl[6])) else $error("no pie");
    a_irq_needs_req: assert property (irq_to_core |-> periph_irq) else $error("no req");
    a_mie_gates_irq: assert property (irq_to_core |-> $past(core_ctrl[7])) else $error("no mie");
    a_mie_off_quiet: assert property ($fell(core_ctrl[7]) |=> !irq_to_core) else $error("mie off");
    a_both_pass_req: assert property (periph_irq && $past(core_ctrl[7:6]) == 2'b11 |-> irq_to_core)
        else $error("lost");
    a_unimpl_zero: assert property ($past(rd_en) |-> (rdata & ~pif_pkg::IMPL_MASK) == 8'h00)
        else $error("unimpl");
    a_disable_drops: assert property (wr_en && addr == pif_pkg::ENABLES_ADDR && wdata == 8'h00 |-> ##2 !periph_irq)
        else $error("en");
    a_reset_quiet: assert property ($rose(rst_n) |-> !periph_irq && !irq_to_core) else $error("reset");
    c_irq: cover property (irq_to_core);
    c_masked: cover property (periph_irq && !irq_to_core);
    c_write: cover property (wr_en);
endmodule
`default_nettype wire

// *** verification/test_peripheral_irq_enable_flag.sv ***
// Bench for the interrupt block and its controller
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module test_peripheral_irq_enable_flag;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0]  ev = 0;
    logic [7:0]  core = 0, r;
    logic [16:0] rows [4] = '{17'h1FFC9, 17'h0C9C9, 17'h00000, 17'h13600};
    int          b [4] = '{0, 3, 6, 7};
    int          miscompares = 0, checks = 0;
    pif_if bus ();
    pif_dev pif_dev_inst (.clk, .rst_n, .bus, .nvm_write_done(ev[3]), .conversion_done(ev[2]),
        .comparator_change(ev[1]), .timer_one_overflow(ev[0]));
    pif_ctl pif_ctl_inst (.clk, .rst_n, .bus, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    pif_asserts pif_asserts_inst (.clk, .rst_n, .addr(bus.addr), .wr_en(bus.wr_en), .rd_en(bus.rd_en),
        .wdata(bus.wdata), .rdata(bus.rdata), .core_ctrl(bus.core_ctrl), .periph_irq(bus.periph_irq),
        .irq_to_core(bus.irq_to_core));
    always #12.5 clk = ~clk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata[7:0];
        psel <= 0;
        penable <= 0;
    endtask
    task automatic dev(input logic w, input logic s, input logic [7:0] d);
        apb(1, 12'h000, {16'h0, d, core[7:3], s, w, 1'b1});
        repeat (3) @(posedge clk);
        r = 1;
        while (r[0] !== 1'b0) apb(0, 12'h004, 0);
        apb(0, 12'h008, 0);
    endtask
    task automatic irq(input logic e);
        apb(0, 12'h004, 0);
        `CHK(r[1], e)
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        dev(0, 1, 0);
        `CHK(r, 8'h00)
        foreach (rows[i]) begin
            dev(1, rows[i][16], rows[i][15:8]);
            dev(0, rows[i][16], 0);
            `CHK(r, rows[i][7:0])
        end
        $display("rows done");
        core = 8'hC0;
        dev(1, 1, 0);
        for (int i = 0; i < 4; i++) begin
            ev <= 4'h1 << i;
            @(posedge clk);
            ev <= 0;
            dev(0, 0, 0);
            `CHK(r[b[i]], 1'b1)
        end
        irq(0);
        $display("events done");
        core = 8'h40;
        dev(1, 1, 8'hC9);
        irq(0);
        `CHK(r[2], 1'b1)
        core = 8'h80;
        dev(1, 1, 8'hC9);
        irq(0);
        core = 8'hC0;
        dev(1, 1, 8'hC9);
        irq(1);
        fork
            dev(1, 0, 0);
            begin
                @(posedge bus.wr_en);
                ev <= 4'h2;
                @(posedge clk);
                ev <= 0;
            end
        join
        dev(0, 0, 0);
        `CHK(r, 8'h08)
        dev(1, 1, 0);
        irq(0);
        `CHK(r[2], 1'b0)
        dev(1, 0, 0);
        dev(1, 1, 8'hC9);
        irq(0);
        $display("gating done");
        ev <= 4'h1;
        @(posedge clk);
        ev <= 0;
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        core = 0;
        dev(0, 0, 0);
        `CHK(r, 8'h00)
        dev(0, 1, 0);
        `CHK(r, 8'h00)
        irq(0);
        $display("reset done");
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done;
    end
endmodule
`default_nettype wire
